// *** hw/swp_pkg.sv ***
// Shared constants and carriers for the sector cache way partitioning block
`default_nettype none

package swp_pkg;

  // ------------------------------------------------------------
  // Configuration register location and layout
  // ------------------------------------------------------------
  localparam logic [7:0]  CFG_ASI      = 8'he7;
  localparam logic [7:0]  CFG_VA       = 8'h00;
  localparam int          LOCK_BIT     = 63;
  localparam int          L2P0_HI      = 20;
  localparam int          L2P0_LO      = 16;
  localparam int          L2P1_HI      = 12;
  localparam int          L2P1_LO      = 8;
  localparam int          L1P0_HI      = 5;
  localparam int          L1P0_LO      = 4;
  localparam int          L1P1_HI      = 1;
  localparam int          L1P1_LO      = 0;
  localparam int          L2_LIMW      = 5;
  localparam int          L1_LIMW      = 2;
  localparam logic [63:0] CFG_RESET    = 64'h0;

  // ------------------------------------------------------------
  // Cache geometry
  // ------------------------------------------------------------
  localparam int          L1_NWAY      = 2;
  localparam int          L2_NWAY      = 24;
  localparam int          LINE_AW      = 16;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic               sector;
    logic [LINE_AW-1:0] line;
  } swp_acc_type;

endpackage : swp_pkg

`default_nettype wire

// *** hw/swp_sector_cache.sv ***
// Sector cache way partitioning: shared config register, per-core L1 and shared L2 sets
//
// Function
// - Locked register accessed outside privileged mode raises a privilege violation.
// - Unlocked register open to all; non-privileged writes keep the lock bit.
// - Bits 20:16 and 12:8 hold L2 way limits for partitions 0 and 1.
// - Bits 5:4 and 1:0 hold L1 way limits for partitions 0 and 1.
// - One configuration register serves all cores.
// - L1 limit writes reach the L1 of every core.
// - L1 and L2 partitioning enable independently from their own limits.
// - One pair of limits applies to every set of a level.
// - Partitioning is active only when both limits are nonzero.
// - Limits above way count clamp to way count; any sum is accepted.
// - Inactive partitioning picks the victim from all ways.
// - Partition under its limit takes the victim from the other partition.
// - Partition at or over its limit takes the victim from itself.
// - Hits occur in any way regardless of partition tags.
// - A hit on a line of the other partition retags it.
// - Each line keeps one tag, set by the most recent access.
// - Tags persist when inactive; L1 evictions carry their tag into L2.
// - Lowering a limit never evicts or invalidates lines by itself.
// - L1 and L2 share one replacement algorithm, own way count and limits.
// - A miss fills an empty way first, tagged with the requesting partition.
// - Within a candidate group the oldest way is the victim.
`default_nettype none

// ------------------------------------------------------------
// One cache level: tags, partition tags, LRU ranks, victim choice
// ------------------------------------------------------------
// same engine
module swp_level
  import swp_pkg::*;
#(
  parameter int NWAY = 2,
  parameter int SETS = 4,
  parameter int LIMW = 2
) (
  input  wire logic            clk,       // core clock
  input  wire logic            rst_n,     // synchronous reset, active low
  input  wire logic            acc_en,    // access this cycle
  input  wire swp_acc_type     acc,       // line and partition of access
  input  wire logic [LIMW-1:0] lim0,      // way limit of partition 0
  input  wire logic [LIMW-1:0] lim1,      // way limit of partition 1
  input  wire logic            retag_en,  // write-back retag this cycle
  input  wire swp_acc_type     retag,     // written-back line and its partition
  output logic                 hit,       // access hits
  output logic                 evict_vld, // access replaces a valid line
  output swp_acc_type          evict      // replaced line and its partition
);
  localparam int WW = (NWAY > 1) ? $clog2(NWAY) : 1;
  localparam int SW = (SETS > 1) ? $clog2(SETS) : 1;

  logic [SETS-1:0][NWAY-1:0]              vld_ff, nxt_vld;
  logic [SETS-1:0][NWAY-1:0]              sec_ff, nxt_sec;
  logic [SETS-1:0][NWAY-1:0][LINE_AW-1:0] tag_ff, nxt_tag;
  logic [SETS-1:0][NWAY-1:0][WW-1:0]      age_ff, nxt_age;

  logic [SW-1:0] idx;
  logic [SW-1:0] ridx;
  logic [WW:0]   lim_c;
  logic [WW:0]   cnt;
  logic [WW-1:0] way;
  logic [WW-1:0] pick;
  logic [WW-1:0] empty_way;
  logic [WW-1:0] hit_way;
  logic [WW-1:0] rway;
  logic [WW-1:0] best;
  logic          any_empty;
  logic          found;
  logic          rhit;
  logic          active;
  logic          grp;

  // ------------------------------------------------------------
  // Lookup and victim selection
  // ------------------------------------------------------------
  always_comb begin
    idx       = acc.line[SW-1:0];
    lim_c     = acc.sector ? (WW+1)'(lim1) : (WW+1)'(lim0);
    if (LIMW > WW + 1) begin
      lim_c = ((acc.sector ? lim1 : lim0) > LIMW'(NWAY)) ? (WW+1)'(NWAY) : lim_c;
    end else if (lim_c > (WW+1)'(NWAY)) begin
      lim_c = (WW+1)'(NWAY);
    end
    active    = (lim0 != '0) && (lim1 != '0);
    hit       = 1'b0;
    hit_way   = '0;
    any_empty = 1'b0;
    empty_way = '0;
    cnt       = '0;
    for (int w = NWAY - 1; w >= 0; w--) begin
      if (vld_ff[idx][w] && tag_ff[idx][w] == acc.line) begin
        hit     = 1'b1;
        hit_way = WW'(w);
      end
      if (!vld_ff[idx][w]) begin
        any_empty = 1'b1;
        empty_way = WW'(w);
      end
      if (vld_ff[idx][w] && sec_ff[idx][w] == acc.sector) begin
        cnt = cnt + 1'b1;
      end
    end
    found = 1'b0;
    best  = '0;
    pick  = '0;
    grp   = 1'b0;
    for (int w = 0; w < NWAY; w++) begin
      grp = 1'b1;
      if (active) begin
        if (cnt < lim_c) begin
          grp = (sec_ff[idx][w] != acc.sector);
        end else begin
          grp = (sec_ff[idx][w] == acc.sector);
        end
      end
      if (grp && (!found || age_ff[idx][w] > best)) begin
        found = 1'b1;
        best  = age_ff[idx][w];
        pick  = WW'(w);
      end
    end
    way          = hit ? hit_way : (any_empty ? empty_way : pick);
    evict_vld    = acc_en && !hit && !any_empty;
    evict.line   = tag_ff[idx][pick];
    evict.sector = sec_ff[idx][pick];
  end

  // ------------------------------------------------------------
  // Next state of the arrays
  // ------------------------------------------------------------
  // Limits are never read here, so lowering one leaves lines alone
  // no forced eviction
  always_comb begin
    nxt_vld = vld_ff;
    nxt_sec = sec_ff;
    nxt_tag = tag_ff;
    nxt_age = age_ff;
    ridx    = retag.line[SW-1:0];
    rhit    = 1'b0;
    rway    = '0;
    for (int w = 0; w < NWAY; w++) begin
      if (vld_ff[ridx][w] && tag_ff[ridx][w] == retag.line) begin
        rhit = 1'b1;
        rway = WW'(w);
      end
    end
    if (retag_en && rhit) begin
      nxt_sec[ridx][rway] = retag.sector;
    end
    if (acc_en) begin
      nxt_vld[idx][way] = 1'b1;
      nxt_tag[idx][way] = acc.line;
      nxt_sec[idx][way] = acc.sector;
      // Ranks stay a permutation, so the oldest way is unique
      for (int w = 0; w < NWAY; w++) begin
        if (age_ff[idx][w] < age_ff[idx][way]) begin
          nxt_age[idx][w] = age_ff[idx][w] + 1'b1;
        end
      end
      nxt_age[idx][way] = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vld_ff <= '0;
      sec_ff <= '0;
      tag_ff <= '0;
      for (int s = 0; s < SETS; s++) begin
        for (int w = 0; w < NWAY; w++) begin
          age_ff[s][w] <= WW'(w);
        end
      end
    end else begin
      vld_ff <= nxt_vld;
      sec_ff <= nxt_sec;
      tag_ff <= nxt_tag;
      age_ff <= nxt_age;
    end
  end

endmodule : swp_level

// ------------------------------------------------------------
// Top: configuration register, core arbitration, both levels
// ------------------------------------------------------------
module swp_sector_cache
  import swp_pkg::*;
#(
  parameter int NCORE   = 2,
  parameter int L1_SETS = 4,
  parameter int L2_SETS = 8
) (
  input  wire logic                     clk,            // core clock
  input  wire logic                     rst_n,          // synchronous reset, active low
  input  wire logic [NCORE-1:0]         core_req_valid, // access request per core
  input  wire swp_acc_type [NCORE-1:0]  core_req,       // line and partition select
  output logic [NCORE-1:0]              core_req_ready, // request taken
  output logic                          resp_valid,     // access result valid
  output logic [$clog2(NCORE)-1:0]      resp_core,      // core of the result
  output logic                          resp_l1_hit,    // hit in that core's L1
  output logic                          resp_l2_hit,    // hit in L2
  input  wire logic                     cfg_req,        // register access
  input  wire logic                     cfg_we,         // write when high
  input  wire logic [7:0]               cfg_asi,        // address space
  input  wire logic [7:0]               cfg_va,         // address within space
  input  wire logic [63:0]              cfg_wdata,      // write data
  input  wire logic                     privileged_mode_flag, // requester is privileged
  output logic                          cfg_ack,        // access done
  output logic [63:0]                   cfg_rdata,      // read data
  output logic                          cfg_priv_viol   // privileged action exception
);
  localparam int CW = $clog2(NCORE);

  // ------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------
  logic               privilege_lock_ff, nxt_lock;
  logic [L2_LIMW-1:0] l2_part0_way_limit_ff, nxt_l2p0;
  logic [L2_LIMW-1:0] l2_part1_way_limit_ff, nxt_l2p1;
  logic [L1_LIMW-1:0] l1_part0_way_limit_ff, nxt_l1p0;
  logic [L1_LIMW-1:0] l1_part1_way_limit_ff, nxt_l1p1;
  logic               cfg_ack_ff, nxt_ack;
  logic               cfg_viol_ff, nxt_viol;
  logic [63:0]        cfg_rdata_ff, nxt_rdata;
  logic               hit_reg;

  always_comb begin
    nxt_lock  = privilege_lock_ff;
    nxt_l2p0  = l2_part0_way_limit_ff;
    nxt_l2p1  = l2_part1_way_limit_ff;
    nxt_l1p0  = l1_part0_way_limit_ff;
    nxt_l1p1  = l1_part1_way_limit_ff;
    nxt_ack   = cfg_req;
    nxt_viol  = 1'b0;
    nxt_rdata = '0;
    hit_reg   = (cfg_asi == CFG_ASI) && (cfg_va == CFG_VA);
    if (cfg_req && hit_reg) begin
      if (privilege_lock_ff && !privileged_mode_flag) begin
        nxt_viol = 1'b1;
      end else if (cfg_we) begin
        if (privileged_mode_flag) begin
          nxt_lock = cfg_wdata[LOCK_BIT];
        end
        nxt_l2p0 = cfg_wdata[L2P0_HI:L2P0_LO];
        nxt_l2p1 = cfg_wdata[L2P1_HI:L2P1_LO];
        nxt_l1p0 = cfg_wdata[L1P0_HI:L1P0_LO];
        nxt_l1p1 = cfg_wdata[L1P1_HI:L1P1_LO];
      end else begin
        nxt_rdata[LOCK_BIT]        = privilege_lock_ff;
        nxt_rdata[L2P0_HI:L2P0_LO] = l2_part0_way_limit_ff;
        nxt_rdata[L2P1_HI:L2P1_LO] = l2_part1_way_limit_ff;
        nxt_rdata[L1P0_HI:L1P0_LO] = l1_part0_way_limit_ff;
        nxt_rdata[L1P1_HI:L1P1_LO] = l1_part1_way_limit_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      privilege_lock_ff     <= CFG_RESET[LOCK_BIT];
      l2_part0_way_limit_ff <= CFG_RESET[L2P0_HI:L2P0_LO];
      l2_part1_way_limit_ff <= CFG_RESET[L2P1_HI:L2P1_LO];
      l1_part0_way_limit_ff <= CFG_RESET[L1P0_HI:L1P0_LO];
      l1_part1_way_limit_ff <= CFG_RESET[L1P1_HI:L1P1_LO];
      cfg_ack_ff            <= 1'b0;
      cfg_viol_ff           <= 1'b0;
      cfg_rdata_ff          <= '0;
    end else begin
      privilege_lock_ff     <= nxt_lock;
      l2_part0_way_limit_ff <= nxt_l2p0;
      l2_part1_way_limit_ff <= nxt_l2p1;
      l1_part0_way_limit_ff <= nxt_l1p0;
      l1_part1_way_limit_ff <= nxt_l1p1;
      cfg_ack_ff            <= nxt_ack;
      cfg_viol_ff           <= nxt_viol;
      cfg_rdata_ff          <= nxt_rdata;
    end
  end

  assign cfg_ack       = cfg_ack_ff;
  assign cfg_priv_viol = cfg_viol_ff;
  assign cfg_rdata     = cfg_rdata_ff;

  // ------------------------------------------------------------
  // Core arbitration: lowest core index first, one access a cycle
  // ------------------------------------------------------------
  logic [NCORE-1:0] gnt;
  logic [CW-1:0]    gidx;
  logic             any_gnt;

  always_comb begin
    gnt     = '0;
    gidx    = '0;
    any_gnt = 1'b0;
    for (int c = NCORE - 1; c >= 0; c--) begin
      if (core_req_valid[c]) begin
        gidx = CW'(c);
      end
    end
    if (|core_req_valid) begin
      any_gnt   = 1'b1;
      gnt[gidx] = 1'b1;
    end
  end

  assign core_req_ready = gnt;

  // ------------------------------------------------------------
  // Per-core L1 and the shared L2
  // ------------------------------------------------------------
  logic [NCORE-1:0]        l1_hit;
  logic [NCORE-1:0]        l1_evict_vld;
  swp_acc_type [NCORE-1:0] l1_evict;
  logic                    l2_hit;

  genvar c;
  generate
    for (c = 0; c < NCORE; c++) begin : g_l1
      swp_level #(.NWAY(L1_NWAY), .SETS(L1_SETS), .LIMW(L1_LIMW)) u_l1 (
        .clk       (clk),
        .rst_n     (rst_n),
        .acc_en    (gnt[c]),
        .acc       (core_req[c]),
        .lim0      (l1_part0_way_limit_ff),
        .lim1      (l1_part1_way_limit_ff),
        .retag_en  (1'b0),
        .retag     ('0),
        .hit       (l1_hit[c]),
        .evict_vld (l1_evict_vld[c]),
        .evict     (l1_evict[c])
      );
    end
  endgenerate

  swp_level #(.NWAY(L2_NWAY), .SETS(L2_SETS), .LIMW(L2_LIMW)) u_l2 (
    .clk       (clk),
    .rst_n     (rst_n),
    .acc_en    (any_gnt && !l1_hit[gidx]),
    .acc       (core_req[gidx]),
    .lim0      (l2_part0_way_limit_ff),
    .lim1      (l2_part1_way_limit_ff),
    .retag_en  (any_gnt && l1_evict_vld[gidx]),
    .retag     (l1_evict[gidx]),
    .hit       (l2_hit),
    .evict_vld (),
    .evict     ()
  );

  // ------------------------------------------------------------
  // Response
  // ------------------------------------------------------------
  logic          resp_valid_ff, nxt_rv;
  logic [CW-1:0] resp_core_ff, nxt_rc;
  logic          resp_l1_ff, nxt_r1;
  logic          resp_l2_ff, nxt_r2;

  always_comb begin
    nxt_rv = any_gnt;
    nxt_rc = gidx;
    nxt_r1 = any_gnt && l1_hit[gidx];
    nxt_r2 = any_gnt && !l1_hit[gidx] && l2_hit;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_valid_ff <= 1'b0;
      resp_core_ff  <= '0;
      resp_l1_ff    <= 1'b0;
      resp_l2_ff    <= 1'b0;
    end else begin
      resp_valid_ff <= nxt_rv;
      resp_core_ff  <= nxt_rc;
      resp_l1_ff    <= nxt_r1;
      resp_l2_ff    <= nxt_r2;
    end
  end

  assign resp_valid  = resp_valid_ff;
  assign resp_core   = resp_core_ff;
  assign resp_l1_hit = resp_l1_ff;
  assign resp_l2_hit = resp_l2_ff;

endmodule : swp_sector_cache

`default_nettype wire

// *** sim/swp_sector_cache_props.sv ***
// Port-level checks for the sector cache way partitioning top
`default_nettype none
module swp_props
  import swp_pkg::*;
#(
  parameter int NCORE = 2
) (
  input wire logic                    clk,                  // core clock
  input wire logic                    rst_n,                // synchronous reset
  input wire logic [NCORE-1:0]        core_req_valid,       // access request
  input wire swp_acc_type [NCORE-1:0] core_req,             // line and select
  input wire logic [NCORE-1:0]        core_req_ready,       // grant
  input wire logic                    resp_valid,           // result valid
  input wire logic [$clog2(NCORE)-1:0] resp_core,           // result core
  input wire logic                    resp_l1_hit,          // L1 hit
  input wire logic                    resp_l2_hit,          // L2 hit
  input wire logic                    cfg_req,              // register access
  input wire logic                    cfg_we,               // write
  input wire logic [7:0]              cfg_asi,              // address space
  input wire logic [7:0]              cfg_va,               // address
  input wire logic [63:0]             cfg_wdata,            // write data
  input wire logic                    privileged_mode_flag, // privileged
  input wire logic                    cfg_ack,              // done
  input wire logic [63:0]             cfg_rdata,            // read data
  input wire logic                    cfg_priv_viol         // violation
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] MASK = 64'h8000_0000_001f_1f33;
  logic map;
  logic refuse;
  logic take_any;
  logic lock_ff;
  logic nxt_lock;
  assign map = (cfg_asi == CFG_ASI) && (cfg_va == CFG_VA);
  assign refuse = cfg_req && map && lock_ff && !privileged_mode_flag;
  assign take_any = |(core_req_valid & core_req_ready);
  // Only reset and a privileged write can move the lock, so a shadow copy suffices
  always_comb begin
    nxt_lock = lock_ff;
    if (!rst_n) begin
      nxt_lock = 1'b0;
    end else if (cfg_req && cfg_we && map && privileged_mode_flag) begin
      nxt_lock = cfg_wdata[LOCK_BIT];
    end
  end
  always_ff @(posedge clk) begin
    lock_ff <= nxt_lock;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_lock_refuse: assert property (refuse |=> cfg_priv_viol && cfg_rdata == 64'h0)
    else $error("locked access not refused");
  a_viol_cause: assert property (cfg_priv_viol |-> cfg_ack && $past(refuse))
    else $error("violation without locked unprivileged access");
  a_open_read: assert property (cfg_req && map && !cfg_we && !refuse
    |=> !cfg_priv_viol && cfg_rdata[LOCK_BIT] == lock_ff) else $error("lock bit read wrong");
  a_write_zero: assert property (cfg_req && cfg_we |=> cfg_rdata == 64'h0)
    else $error("write returned data");
  a_reserved_zero: assert property (cfg_ack |-> (cfg_rdata & ~MASK) == 64'h0)
    else $error("reserved bits nonzero");
  a_grant_lowest: assert property (core_req_ready ==
    (core_req_valid & (~core_req_valid + 1'b1))) else $error("grant not lowest core");
  a_resp_timing: assert property (resp_valid == $past(take_any))
    else $error("response not one cycle after grant");
  a_hit_level: assert property (resp_l1_hit || resp_l2_hit
    |-> resp_valid && !(resp_l1_hit && resp_l2_hit)) else $error("bad hit flags");
  c_locked: cover property (refuse);
  c_contend: cover property (core_req_valid == '1);
  c_l1_hit: cover property (resp_valid && resp_l1_hit);
endmodule : swp_props

bind swp_sector_cache swp_props #(.NCORE(NCORE)) u_props (
  .clk(clk), .rst_n(rst_n), .core_req_valid(core_req_valid), .core_req(core_req),
  .core_req_ready(core_req_ready), .resp_valid(resp_valid), .resp_core(resp_core),
  .resp_l1_hit(resp_l1_hit), .resp_l2_hit(resp_l2_hit), .cfg_req(cfg_req),
  .cfg_we(cfg_we), .cfg_asi(cfg_asi), .cfg_va(cfg_va), .cfg_wdata(cfg_wdata),
  .privileged_mode_flag(privileged_mode_flag), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .cfg_priv_viol(cfg_priv_viol));
`default_nettype wire

// *** sim/swp_core_model.sv ***
// Core request model driving the access port
`default_nettype none
module swp_core_model
  import swp_pkg::*;
#(
  parameter int NCORE = 2
) (
  input  wire logic                  clk,            // core clock
  input  wire logic [NCORE-1:0]      core_req_ready, // grant
  output var logic [NCORE-1:0]       core_req_valid, // request per core
  output var swp_acc_type [NCORE-1:0] core_req       // line and select
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    core_req_valid = '0;
    core_req = '0;
  end
  task automatic issue(input int c, input logic s, input logic [LINE_AW-1:0] ln,
                       input int gap, output logic ok);
    ok = 1'b0;
    repeat (gap + 1) @(posedge clk);
    #1;
    core_req[c] = '{sector: s, line: ln};
    core_req_valid[c] = 1'b1;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (core_req_ready[c] === 1'b1);
    end
    #1;
    core_req_valid[c] = 1'b0;
    // Released lines must not keep looking like a request
    core_req[c] = swp_acc_type'(~core_req[c]);
  endtask : issue
endmodule : swp_core_model
`default_nettype wire

// *** sim/test_sector_cache_way_partition.sv ***
// Self-checking bench for the sector cache way partitioning block
`default_nettype none
module test_sector_cache_way_partition
  import swp_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] MASK = 64'h8000_0000_001f_1f33;
  localparam logic [63:0] LCK  = 64'h8000_0000_0000_0000;
  localparam logic [63:0] LIM [4] = '{64'h11, 64'h01, 64'h31, 64'h11};
  // Entry: core, sector, l1 hit, l2 hit, line
  localparam logic [19:0] SEQ [24] = '{
    20'h4_0100, 20'h0_0200, 20'h0_0300, 20'h6_0100, 20'h1_0200, 20'h6_0100,
    20'h4_1101, 20'h0_1201, 20'h0_1301, 20'h2_1201, 20'h5_1101, 20'h2_1201,
    20'h0_2202, 20'h4_2102, 20'h0_2302, 20'h2_2202, 20'h5_2102, 20'h2_2202,
    20'h8_3203, 20'hc_3103, 20'he_3203, 20'h8_3303, 20'he_3203, 20'hd_3103};
  logic              clk;
  logic              rst_n;
  logic [1:0]        valid;
  logic [1:0]        ready;
  swp_acc_type [1:0] req;
  logic              rv;
  logic              rc;
  logic              rl1;
  logic              rl2;
  logic              cfg_req;
  logic              cfg_we;
  logic              priv;
  logic [7:0]        asi;
  logic [7:0]        va;
  logic [63:0]       wdata;
  logic [63:0]       rdata;
  logic              ack;
  logic              viol;
  logic [2:0]        acc_q [$];
  logic [64:0]       cfg_q [$];
  logic [2:0]        ae;
  logic [64:0]       ce;
  logic [19:0]       e;
  logic [63:0]       w;
  logic [31:0]       seed;
  logic              ok0;
  logic              ok1;
  int                num_errors;
  int                num_checks;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  swp_sector_cache dut (.clk(clk), .rst_n(rst_n), .core_req_valid(valid), .core_req(req),
    .core_req_ready(ready), .resp_valid(rv), .resp_core(rc), .resp_l1_hit(rl1),
    .resp_l2_hit(rl2), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_asi(asi), .cfg_va(va),
    .cfg_wdata(wdata), .privileged_mode_flag(priv), .cfg_ack(ack), .cfg_rdata(rdata),
    .cfg_priv_viol(viol));
  swp_core_model m (.clk(clk), .core_req_ready(ready), .core_req_valid(valid),
    .core_req(req));
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic cfg(input logic we, input logic p, input logic [7:0] a,
                     input logic [63:0] d, input logic [64:0] x);
    cfg_q.push_back(x);
    @(posedge clk);
    #1;
    cfg_req = 1'b1;
    cfg_we = we;
    priv = p;
    asi = a;
    wdata = d;
    @(posedge clk);
    #1;
    cfg_req = 1'b0;
    wdata = ~wdata;
  endtask : cfg
  // Result and register monitors take the oldest note per answer
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      ae = (acc_q.size() > 0) ? acc_q.pop_front() : 3'bxxx;
      check("resp", {rc, rl1, rl2}, ae);
    end
    if (ack === 1'b1) begin
      ce = (cfg_q.size() > 0) ? cfg_q.pop_front() : {65{1'bx}};
      check("cfg_rdata", rdata, ce[63:0]);
      check("cfg_viol", viol, ce[64]);
    end
  end
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    priv = 1'b0;
    asi = 8'h00;
    va = CFG_VA;
    wdata = 64'h0;
    seed = 32'haf9a;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    seed = lfsr(seed);
    w = {seed, lfsr(seed)} & ~LCK;
    cfg(1'b0, 1'b1, CFG_ASI, 64'h0, 65'h0);
    cfg(1'b1, 1'b1, CFG_ASI, w, 65'h0);
    cfg(1'b0, 1'b0, CFG_ASI, 64'h0, {1'b0, w & MASK});
    // Unprivileged write must not set the lock
    cfg(1'b1, 1'b0, CFG_ASI, ~w, 65'h0);
    cfg(1'b0, 1'b1, CFG_ASI, 64'h0, {1'b0, ~w & MASK & ~LCK});
    cfg(1'b1, 1'b1, CFG_ASI ^ 8'h01, w, 65'h0);
    cfg(1'b0, 1'b1, CFG_ASI ^ 8'h01, 64'h0, 65'h0);
    va = CFG_VA ^ 8'h01;
    cfg(1'b1, 1'b1, CFG_ASI, w, 65'h0);
    cfg(1'b0, 1'b1, CFG_ASI, 64'h0, 65'h0);
    va = CFG_VA;
    // Neither stray write may have landed
    cfg(1'b0, 1'b1, CFG_ASI, 64'h0, {1'b0, ~w & MASK & ~LCK});
    cfg(1'b1, 1'b1, CFG_ASI, w | LCK, 65'h0);
    cfg(1'b0, 1'b0, CFG_ASI, 64'h0, {1'b1, 64'h0});
    cfg(1'b1, 1'b0, CFG_ASI, 64'h0, {1'b1, 64'h0});
    cfg(1'b0, 1'b1, CFG_ASI, 64'h0, {1'b0, (w | LCK) & MASK});
    for (int g = 0; g < 4; g++) begin
      cfg(1'b1, 1'b1, CFG_ASI, LIM[g], 65'h0);
      for (int i = 0; i < 6; i++) begin
        e = SEQ[g * 6 + i];
        acc_q.push_back({e[19], e[17:16]});
        m.issue(int'(e[19]), e[18], e[15:0], i % 2, ok0);
        check("grant", ok0, 1'b1);
      end
    end
    // Both cores at once; the second sees the line the first core brought in
    acc_q.push_back(3'b010);
    acc_q.push_back(3'b101);
    fork
      m.issue(0, 1'b1, 16'h0100, 0, ok0);
      m.issue(1, 1'b0, 16'h0200, 0, ok1);
    join
    check("contend", {ok0, ok1}, 2'b11);
    // L2 on, L1 off: 24 partition 1 lines fill one L2 set, then two partition 0
    // misses; the second must displace the first, so the old line 0x400d survives
    cfg(1'b1, 1'b1, CFG_ASI, 64'h0001_0100, 65'h0);
    for (int k = 0; k < 27; k++) begin
      acc_q.push_back({1'b1, 1'b0, k == 26});
      m.issue(1, !(k inside {24, 25}), 16'h4005 + 16'(8 * ((k == 26) ? 1 : k)), 0, ok1);
      check("l2_grant", ok1, 1'b1);
    end
    for (int i = 0; i < 50 && (acc_q.size() + cfg_q.size()) > 0; i++) begin
      @(posedge clk);
    end
    check("drain", acc_q.size() + cfg_q.size(), 64'h0);
    end_sim();
  end
endmodule : test_sector_cache_way_partition
`default_nettype wire
